// ==== dpll_limit_divider_defines.svh ====
`ifndef DPLL_LIMIT_DIVIDER_DEFINES_SVH
`define DPLL_LIMIT_DIVIDER_DEFINES_SVH

// Register offsets
`define REG_LIMIT_LOW_ADDR   8'h41
`define REG_LIMIT_HIGH_ADDR  8'h42
`define REG_RATIO_LOW_ADDR   8'h46
`define REG_RATIO_HIGH_ADDR  8'h47
`define REG_BANK_ADDR        8'h4B

// Widths
`define ADDR_W               8
`define DATA_W               8
`define LIMIT_W              10
`define LIMIT_HIGH_W         2
`define RATIO_W              14
`define RATIO_HIGH_W         6
`define NUM_INPUTS           2

// Field positions
`define BANK_SEL_BIT         4

// Reset values
`define LIMIT_LOW_RESET      8'hFF
`define LIMIT_HIGH_RESET     2'h3
`define RATIO_LOW_RESET      8'hFF
`define RATIO_HIGH_RESET     6'h3F
`define BANK_RESET           1'h0

// Largest ratio software may program
`define RATIO_MAX            14'h30D3

`endif

// ==== dpll_limit_divider_pkg.sv ====
`include "dpll_limit_divider_defines.svh"

package dpll_limit_divider_pkg;

  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   wdata;
  } reg_req_s;

  typedef struct packed {
    logic [`DATA_W-1:0]       limit_low;
    logic [`LIMIT_HIGH_W-1:0] limit_high;
    logic [`DATA_W-1:0]       ratio_low;
    logic [`RATIO_HIGH_W-1:0] ratio_high;
    logic                     bank;
    logic [`DATA_W-1:0]       read_data;
  } regs_state_s;

  typedef struct packed {
    logic [`RATIO_W-1:0] count;
    logic                pulse;
  } div_state_s;

endpackage

// ==== predivider.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpll_limit_divider_defines.svh"

module predivider
  import dpll_limit_divider_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  input  wire logic [`RATIO_W-1:0] ratio_i,
  input  wire logic                enable_i,
  input  wire logic                tick_i,
  output logic                     tick_o
);

  div_state_s state;
  div_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (!enable_i) begin
      next_state.count = '0;
      next_state.pulse = tick_i;
    end else if (tick_i) begin
      // Divide by ratio plus one
      if (state.count >= ratio_i) begin
        next_state.count = '0;
        next_state.pulse = 1'b1;
      end else begin
        next_state.count = state.count + `RATIO_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick_o = state.pulse;

endmodule
`default_nettype wire

// ==== dpll_limit_divider_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpll_limit_divider_defines.svh"

module dpll_limit_divider_regs
  import dpll_limit_divider_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   reset_i,
  input  wire reg_req_s               reg_req_i,
  output logic [`DATA_W-1:0]          read_data_o,
  output logic [`LIMIT_W-1:0]         loop_pull_in_limit_o,
  output logic [`RATIO_W-1:0]         predivider_ratio_o,
  output logic                        loop_bank_choice_o,
  input  wire logic [`NUM_INPUTS-1:0] use_predivider_i,
  input  wire logic [`NUM_INPUTS-1:0] in_tick_i,
  output logic [`NUM_INPUTS-1:0]      out_tick_o
);

  regs_state_s state;
  regs_state_s next_state;
  logic        wr;
  logic        rd;

  assign wr = reg_req_i.valid && reg_req_i.write;
  assign rd = reg_req_i.valid && !reg_req_i.write;

  always_comb begin
    next_state = state;
    if (wr) begin
      unique case (reg_req_i.addr)
        `REG_LIMIT_LOW_ADDR:  next_state.limit_low = reg_req_i.wdata;
        `REG_LIMIT_HIGH_ADDR: next_state.limit_high =
                                reg_req_i.wdata[`LIMIT_HIGH_W-1:0];
        `REG_RATIO_LOW_ADDR:  next_state.ratio_low = reg_req_i.wdata;
        `REG_RATIO_HIGH_ADDR: next_state.ratio_high =
                                reg_req_i.wdata[`RATIO_HIGH_W-1:0];
        `REG_BANK_ADDR:       next_state.bank =
                                reg_req_i.wdata[`BANK_SEL_BIT];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (reg_req_i.addr)
        `REG_LIMIT_LOW_ADDR:  next_state.read_data = state.limit_low;
        `REG_LIMIT_HIGH_ADDR: next_state.read_data =
                                {6'h00, state.limit_high};
        `REG_RATIO_LOW_ADDR:  next_state.read_data = state.ratio_low;
        `REG_RATIO_HIGH_ADDR: next_state.read_data =
                                {2'h0, state.ratio_high};
        `REG_BANK_ADDR:       next_state.read_data =
                                {3'h0, state.bank, 4'h0};
        default:              next_state.read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state.limit_low  <= `LIMIT_LOW_RESET;
      state.limit_high <= `LIMIT_HIGH_RESET;
      state.ratio_low  <= `RATIO_LOW_RESET;
      state.ratio_high <= `RATIO_HIGH_RESET;
      state.bank       <= `BANK_RESET;
      state.read_data  <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign read_data_o          = state.read_data;
  assign loop_pull_in_limit_o = {state.limit_high, state.limit_low};
  assign predivider_ratio_o   = {state.ratio_high, state.ratio_low};
  assign loop_bank_choice_o   = state.bank;

  // One pre-divider per input
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_INPUTS; gi++) begin : g_div
      predivider u_div (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .ratio_i  (predivider_ratio_o),
        .enable_i (use_predivider_i[gi]),
        .tick_i   (in_tick_i[gi]),
        .tick_o   (out_tick_o[gi])
      );
    end
  endgenerate

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // Ticks counted on input 0 since its last output
  logic [`RATIO_W:0] tick_count;
  logic              ratio_dirty;
  logic              use_dirty;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_count  <= '0;
      ratio_dirty <= 1'b0;
      use_dirty   <= 1'b0;
    end else if (out_tick_o[0]) begin
      tick_count  <= {{`RATIO_W{1'b0}}, in_tick_i[0]};
      ratio_dirty <= wr && (reg_req_i.addr == `REG_RATIO_LOW_ADDR ||
                            reg_req_i.addr == `REG_RATIO_HIGH_ADDR);
      use_dirty   <= !use_predivider_i[0];
    end else begin
      tick_count  <= tick_count + {{`RATIO_W{1'b0}}, in_tick_i[0]};
      ratio_dirty <= ratio_dirty || (wr && (reg_req_i.addr == `REG_RATIO_LOW_ADDR ||
                                            reg_req_i.addr == `REG_RATIO_HIGH_ADDR));
      use_dirty   <= use_dirty || !use_predivider_i[0];
    end
  end

  logic seen_reset;
  always_ff @(posedge clock_i) begin
    seen_reset <= reset_i;
  end

  sequence s_write_high;
    wr && reg_req_i.addr == `REG_RATIO_HIGH_ADDR;
  endsequence

  sequence s_write_low;
    wr && reg_req_i.addr == `REG_RATIO_LOW_ADDR;
  endsequence

  property p_limit_high_write;
    wr && reg_req_i.addr == `REG_LIMIT_HIGH_ADDR |=>
      loop_pull_in_limit_o[`LIMIT_W-1:`DATA_W] == $past(reg_req_i.wdata[1:0]);
  endproperty
  a_limit_high_write: assert property (p_limit_high_write)
    else $error("limit high bits not written");

  property p_limit_low_write;
    wr && reg_req_i.addr == `REG_LIMIT_LOW_ADDR |=>
      loop_pull_in_limit_o[`DATA_W-1:0] == $past(reg_req_i.wdata);
  endproperty
  a_limit_low_write: assert property (p_limit_low_write)
    else $error("limit low byte not written");

  property p_ratio_pair;
    s_write_high ##1 (s_write_low and (reg_req_i.wdata == 8'h00)) |=>
      predivider_ratio_o == {$past(reg_req_i.wdata[5:0], 2), 8'h00};
  endproperty
  a_ratio_pair: assert property (p_ratio_pair)
    else $error("ratio not formed from both bytes");

  property p_reset_values;
    seen_reset && !reset_i |->
      predivider_ratio_o == 14'h3FFF && loop_pull_in_limit_o == 10'h3FF &&
      !loop_bank_choice_o;
  endproperty
  a_reset_values: assert property (disable iff (1'b0) p_reset_values)
    else $error("wrong value after reset");

  property p_divide_by_ratio;
    out_tick_o[0] && use_predivider_i[0] && !ratio_dirty && !use_dirty |->
      tick_count == {1'b0, predivider_ratio_o} + 15'h0001;
  endproperty
  a_divide_by_ratio: assert property (p_divide_by_ratio)
    else $error("pre-divider period is not ratio plus one");

  property p_bank_write;
    wr && reg_req_i.addr == `REG_BANK_ADDR |=>
      loop_bank_choice_o == $past(reg_req_i.wdata[`BANK_SEL_BIT]) ##1
      loop_bank_choice_o == $past(reg_req_i.wdata[`BANK_SEL_BIT], 2) ||
      (wr && reg_req_i.addr == `REG_BANK_ADDR) ||
      $past(wr && reg_req_i.addr == `REG_BANK_ADDR);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("bank select not taken from bit 4");

  property p_unused_read_zero;
    rd && reg_req_i.addr == `REG_RATIO_HIGH_ADDR |=>
      read_data_o[7:6] == 2'h0 && read_data_o[5:0] == predivider_ratio_o[13:8];
  endproperty
  a_unused_read_zero: assert property (p_unused_read_zero)
    else $error("unused ratio bits not zero on read");

  property p_bank_read;
    rd && reg_req_i.addr == `REG_BANK_ADDR |=>
      read_data_o == {3'h0, loop_bank_choice_o, 4'h0};
  endproperty
  a_bank_read: assert property (p_bank_read)
    else $error("bank register reads unused bits");

endmodule
`default_nettype wire

// ==== dpll_limit_divider_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpll_limit_divider_defines.svh"

module dpll_limit_divider_regs_tb
  import dpll_limit_divider_pkg::*;
;
  logic                   clock_i;
  logic                   reset_i;
  reg_req_s               req;
  logic [`DATA_W-1:0]     read_data_o;
  logic [`LIMIT_W-1:0]    loop_pull_in_limit_o;
  logic [`RATIO_W-1:0]    predivider_ratio_o;
  logic                   loop_bank_choice_o;
  logic [`NUM_INPUTS-1:0] use_predivider;
  logic [`NUM_INPUTS-1:0] in_tick;
  logic [`NUM_INPUTS-1:0] out_tick_o;
  int                     errors;
  int                     num_checks;

  dpll_limit_divider_regs u_dut (
    .clock_i              (clock_i),
    .reset_i              (reset_i),
    .reg_req_i            (req),
    .read_data_o          (read_data_o),
    .loop_pull_in_limit_o (loop_pull_in_limit_o),
    .predivider_ratio_o   (predivider_ratio_o),
    .loop_bank_choice_o   (loop_bank_choice_o),
    .use_predivider_i     (use_predivider),
    .in_tick_i            (in_tick),
    .out_tick_o           (out_tick_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Access held for one rising edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    req = '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
    @(negedge clock_i);
    req.valid = 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    req = '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    req.valid = 1'b0;
    check(16'(read_data_o), 16'(exp));
  endtask

  // One tick pulse, output seen one cycle later
  task automatic tick(input logic [1:0] t, input logic [1:0] exp);
    @(negedge clock_i);
    in_tick = t;
    @(negedge clock_i);
    in_tick = 2'h0;
    check(16'(out_tick_o), 16'(exp));
  endtask

  initial begin
    #50_000;
    errors++;
    report_and_stop();
  end

  initial begin
    errors         = 0;
    num_checks     = 0;
    reset_i        = 1'b1;
    req            = '0;
    use_predivider = 2'h0;
    in_tick        = 2'h0;
    repeat (16) @(negedge clock_i);
    reset_i = 1'b0;
    // Reset values
    check(16'(loop_pull_in_limit_o), 16'h03FF);
    check(16'(predivider_ratio_o), 16'h3FFF);
    check(16'(loop_bank_choice_o), 16'h0000);
    read_reg(`REG_LIMIT_LOW_ADDR, 8'hFF);
    read_reg(`REG_LIMIT_HIGH_ADDR, 8'h03);
    read_reg(`REG_RATIO_LOW_ADDR, 8'hFF);
    read_reg(`REG_RATIO_HIGH_ADDR, 8'h3F);
    read_reg(`REG_BANK_ADDR, 8'h00);
    // Unused bits and unmapped place
    write_reg(`REG_LIMIT_HIGH_ADDR, 8'hFE);
    read_reg(`REG_LIMIT_HIGH_ADDR, 8'h02);
    write_reg(`REG_LIMIT_LOW_ADDR, 8'h5A);
    check(16'(loop_pull_in_limit_o), 16'h025A);
    write_reg(`REG_BANK_ADDR, 8'hFF);
    read_reg(`REG_BANK_ADDR, 8'h10);
    check(16'(loop_bank_choice_o), 16'h0001);
    write_reg(`REG_BANK_ADDR, 8'hEF);
    check(16'(loop_bank_choice_o), 16'h0000);
    read_reg(8'h50, 8'h00);
    // Largest allowed ratio
    write_reg(`REG_RATIO_LOW_ADDR, 8'hD3);
    write_reg(`REG_RATIO_HIGH_ADDR, 8'hF0);
    check(16'(predivider_ratio_o), 16'h30D3);
    read_reg(`REG_RATIO_HIGH_ADDR, 8'h30);
    // High then low byte on back to back edges
    @(negedge clock_i);
    req = '{valid: 1'b1, write: 1'b1, addr: `REG_RATIO_HIGH_ADDR, wdata: 8'h05};
    @(negedge clock_i);
    req = '{valid: 1'b1, write: 1'b1, addr: `REG_RATIO_LOW_ADDR, wdata: 8'h00};
    @(negedge clock_i);
    req.valid = 1'b0;
    check(16'(predivider_ratio_o), 16'h0500);
    // Ratio two, input 0 divided, input 1 passed
    write_reg(`REG_RATIO_LOW_ADDR, 8'h02);
    write_reg(`REG_RATIO_HIGH_ADDR, 8'h00);
    check(16'(predivider_ratio_o), 16'h0002);
    // Ticks come at most every other clock, well under 100 MHz
    use_predivider = 2'h1;
    for (int k = 0; k < 6; k++) begin
      tick(2'h3, {1'b1, (k == 2) || (k == 5)});
    end
    // Ratio zero passes every tick
    write_reg(`REG_RATIO_LOW_ADDR, 8'h00);
    use_predivider = 2'h3;
    for (int k = 0; k < 3; k++) begin
      tick(2'h3, 2'h3);
    end
    // Second reset restores defaults
    @(negedge clock_i);
    reset_i = 1'b1;
    @(negedge clock_i);
    reset_i = 1'b0;
    check(16'(predivider_ratio_o), 16'h3FFF);
    check(16'(loop_pull_in_limit_o), 16'h03FF);
    report_and_stop();
  end
endmodule
`default_nettype wire
